// [pspa_top.sv]
// Power stage auxiliary logic: outputs, capture, sync, chain, registers
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module pspa_top #(
  parameter int CW = 12,
  parameter bit CHAIN_EN = 1'b0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [pspa_pkg::AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [pspa_pkg::DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [pspa_pkg::AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [pspa_pkg::DW-1:0] rdata,
  output logic [1:0] rresp,
  // Core ramp generator side
  input wire logic core_out0,
  input wire logic core_out1,
  input wire logic [1:0] ramp_idx,
  input wire logic [CW-1:0] count_in,
  input wire logic reload_ev,
  input wire logic enh_end_ev,
  input wire logic sync_err_ev,
  // Retrigger or fault input and clock sources
  input wire logic retrig_in,
  input wire logic io_tick,
  input wire logic pll_tick,
  // Run daisy chain
  input wire logic prev_run_in,
  input wire logic next_fault_in,
  output logic run_out,
  output logic fault_to_prev,
  // Pins
  output logic third_ctrl_out0,
  output logic third_ctrl_out1,
  output logic dup_out_a,
  output logic dup_out_b,
  output logic adc_sync,
  output logic clk_psc_tick
);
  import pspa_pkg::*;
  if (CW < 1 || CW > 16) begin : g_bad_width
    $error("counter width out of range");
  end
  // All state of the block except the prescaler and the delay line
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [31:0] ocfg;
    logic [31:0] mat;
    logic [31:0] dly;
    logic [31:0] stat;
    logic [CW-1:0] cap;
    logic act_prev;
    logic [1:0] div4;
    logic out0;
    logic out1;
    logic o0p;
    logic o1p;
    logic dupa;
    logic dupb;
    logic run_o;
    logic flt_o;
    logic awh;
    logic [AW-1:0] awa;
    logic wh;
    logic [31:0] wd;
    logic [3:0] ws;
    pspa_wr_st_t wst;
    logic bv;
    logic [1:0] br;
    logic awr;
    logic wr;
    logic arr;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } pspa_top_st_t;
  pspa_top_st_t s_q, s_d;
  // Combinational helpers
  logic act;
  logic ev;
  logic [3:0] mode;
  logic mat_on;
  logic deact;
  logic inact;
  logic o0;
  logic o1;
  logic sync_pulse;
  logic shift_en;
  logic psc_tick;
  logic [31:0] chain_msk;

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] strb,
                                         input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    wmerge = r & msk;
  endfunction : wmerge

  // Known register addresses
  function automatic logic mapped(input logic [AW-1:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_CFG) || (a == OFS_OCFG) ||
             (a == OFS_MAT) || (a == OFS_DLY) || (a == OFS_CAP) ||
             (a == OFS_STAT);
  endfunction : mapped

  // Next state of bus, registers and output path
  always_comb begin
    s_d = s_q;
    // Chain bits are stuck at zero when chaining is absent
    chain_msk = CHAIN_EN ? MSK_CTRL : (MSK_CTRL & ~MSK_CHAIN);
    // Write address and data are taken in either order
    if (!s_q.awh && awvalid && s_q.awr) begin
      s_d.awh = 1'b1;
      s_d.awa = awaddr;
    end
    if (!s_q.wh && wvalid && s_q.wr) begin
      s_d.wh = 1'b1;
      s_d.wd = wdata;
      s_d.ws = wstrb;
    end
    // Write channel sequencing
    case (s_q.wst)
      WR_IDLE: begin
        if (s_q.awh && s_q.wh) begin
          s_d.awh = 1'b0;
          s_d.wh = 1'b0;
          s_d.bv = 1'b1;
          s_d.wst = WR_RESP;
          s_d.br = mapped(s_q.awa) ? RESP_OKAY : RESP_SLVERR;
          case (s_q.awa)
            OFS_CTRL: begin
              s_d.ctrl = wmerge(s_q.ctrl, s_q.wd, s_q.ws, chain_msk);
            end
            OFS_CFG: begin
              // Mode field is stored whole; reserved codes act as none
              s_d.cfg = wmerge(s_q.cfg, s_q.wd, s_q.ws, MSK_CFG);
            end
            OFS_OCFG: begin
              s_d.ocfg = wmerge(s_q.ocfg, s_q.wd, s_q.ws, MSK_OCFG);
            end
            OFS_MAT: begin
              s_d.mat = wmerge(s_q.mat, s_q.wd, s_q.ws, MSK_MAT);
            end
            OFS_DLY: begin
              s_d.dly = wmerge(s_q.dly, s_q.wd, s_q.ws, MSK_DLY);
            end
            OFS_STAT: begin
              // Write one to clear a flag
              s_d.stat = s_q.stat & ~wmerge(32'h0, s_q.wd, s_q.ws,
                                            MSK_STAT);
            end
            default: begin
              // Capture is read only; unmapped writes are dropped
            end
          endcase
        end
      end
      WR_RESP: begin
        if (bready) begin
          s_d.bv = 1'b0;
          s_d.wst = WR_IDLE;
        end
      end
      default: begin
        s_d.wst = WR_IDLE;
      end
    endcase
    s_d.awr = !s_d.awh;
    s_d.wr = !s_d.wh;
    // Read channel
    if (s_q.rv && rready) begin
      s_d.rv = 1'b0;
    end
    if (arvalid && s_q.arr) begin
      s_d.rv = 1'b1;
      s_d.rr = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        OFS_CTRL: s_d.rd = s_q.ctrl;
        OFS_CFG: s_d.rd = s_q.cfg;
        OFS_OCFG: s_d.rd = s_q.ocfg;
        OFS_MAT: s_d.rd = s_q.mat;
        OFS_DLY: s_d.rd = s_q.dly;
        OFS_CAP: s_d.rd = 32'(s_q.cap);
        OFS_STAT: s_d.rd = s_q.stat;
        default: s_d.rd = 32'h0;
      endcase
    end
    s_d.arr = !s_d.rv;

    // Input event: rise of the active level, edge or level mode alike
    act = s_q.cfg[CFG_ACT_HI] ? retrig_in : !retrig_in;
    ev = act && !s_q.act_prev;
    s_d.act_prev = act;
    mode = s_q.cfg[CFG_MODE_LO +: 4];
    // Capture overwrites with no loss protection, same cycle as event
    if (ev) begin
      s_d.cap = count_in;
    end
    // Sticky flags; a set wins over a clear in the same cycle
    s_d.stat[ST_RELOAD] = s_d.stat[ST_RELOAD] | reload_ev;
    s_d.stat[ST_ENH] = s_d.stat[ST_ENH] | enh_end_ev;
    s_d.stat[ST_INPUT] = s_d.stat[ST_INPUT] | ev;
    s_d.stat[ST_SYNCERR] = s_d.stat[ST_SYNCERR] | sync_err_ev;

    // Mode 7 faults halt run, including one sent back by a slave
    if (CHAIN_EN && mode == IM_HALT && (ev || next_fault_in)) begin
      s_d.ctrl[CTRL_RUN] = 1'b0;
    end
    // Slave hands its enabled mode 7 fault to the run supplier
    s_d.flt_o = CHAIN_EN && mode == IM_HALT && act &&
                s_q.ctrl[CTRL_AUTORUN];
    // Run passes on; an autorun slave starts and stops with it
    s_d.run_o = CHAIN_EN && (s_q.ctrl[CTRL_RUN] ||
                (s_q.ctrl[CTRL_AUTORUN] && prev_run_in));

    // Matrix only in four-ramp mode; polarity then has no effect
    mat_on = s_q.cfg[CFG_MAT_EN] && s_q.cfg[CFG_RUN_LO +: 2] == RM_FOUR;
    if (mat_on) begin
      o0 = s_q.mat[{1'b0, ramp_idx}];
      o1 = s_q.mat[{1'b1, ramp_idx}];
      inact = 1'b0;
    end else begin
      o0 = core_out0 ^ s_q.cfg[CFG_POL];
      o1 = core_out1 ^ s_q.cfg[CFG_POL];
      inact = s_q.cfg[CFG_POL];
    end
    // Mode 14 (and 4) mask outputs while active; ramp and period run on
    deact = (mode == IM_FFDEACT || mode == IM_DEACT) && act;
    // Reserved and unused codes fall through with no output action
    if (deact) begin
      o0 = inact;
      o1 = inact;
    end
    s_d.out0 = o0;
    s_d.out1 = o1;
    s_d.dupa = s_d.ocfg[OCFG_DUPA] ? o1 : o0;
    s_d.dupb = s_d.ocfg[OCFG_DUPB] ? o0 : o1;

    // Sync source edge select, one cycle behind the pins
    s_d.o0p = s_q.out0;
    s_d.o1p = s_q.out1;
    if (s_q.cfg[CFG_RUN_LO +: 2] == RM_CENTER) begin
      // Centered mode: only the two output-0 codes give a pulse
      case (s_q.ocfg[OCFG_SRC_LO +: 2])
        SS_LEAD0: sync_pulse = !s_q.out0 && s_q.o0p;
        SS_TRAIL0: sync_pulse = s_q.out0 && !s_q.o0p;
        default: sync_pulse = 1'b0;
      endcase
    end else begin
      case (s_q.ocfg[OCFG_SRC_LO +: 2])
        SS_LEAD0: sync_pulse = s_q.out0 && !s_q.o0p;
        SS_TRAIL0: sync_pulse = !s_q.out0 && s_q.o0p;
        SS_LEAD1: sync_pulse = s_q.out1 && !s_q.o1p;
        SS_TRAIL1: sync_pulse = !s_q.out1 && s_q.o1p;
        default: sync_pulse = 1'b0;
      endcase
    end
    // Shift clock is the controller tick or a quarter of it
    if (psc_tick) begin
      s_d.div4 = s_q.div4 + 2'h1;
    end
    shift_en = s_q.ocfg[OCFG_DLYCLK] ?
               (psc_tick && s_q.div4 == SHIFT_DIV_LAST) : psc_tick;
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Controller clock source and prescaler
  pspa_prescale u_pre (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .io_tick(io_tick),
    .pll_tick(pll_tick),
    .src_pll(s_q.ctrl[CTRL_CLKSEL]),
    .div_sel(s_q.ctrl[CTRL_PRE_LO +: 2]),
    .tick_q(psc_tick)
  );

  // ADC sync delay line
  pspa_sync_delay #(.DLW(8)) u_dly (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pulse(sync_pulse),
    .shift_en(shift_en),
    .delay(s_q.dly[7:0]),
    .sync_q(adc_sync)
  );

  // Outputs straight from the state register; the clock tick comes from the prescaler
  assign awready = s_q.awr;
  assign wready = s_q.wr;
  assign bvalid = s_q.bv;
  assign bresp = s_q.br;
  assign arready = s_q.arr;
  assign rvalid = s_q.rv;
  assign rdata = s_q.rd;
  assign rresp = s_q.rr;
  assign run_out = s_q.run_o;
  assign fault_to_prev = s_q.flt_o;
  assign third_ctrl_out0 = s_q.out0;
  assign third_ctrl_out1 = s_q.out1;
  assign dup_out_a = s_q.dupa;
  assign dup_out_b = s_q.dupb;
  assign clk_psc_tick = psc_tick;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Capture event and its effects
  // No capture at the release edge: the state is still held in reset there
  sequence s_in_event;
    nrst && act && !s_q.act_prev;
  endsequence
  sequence s_captured;
    s_q.cap == $past(count_in) && s_q.stat[ST_INPUT];
  endsequence

  a_cap_update: assert property (s_in_event |=> s_captured)
    else $error("capture or flag missed the event");
  a_cap_hold: assert property (!ev |=> s_q.cap == $past(s_q.cap))
    else $error("capture changed without an event");
  a_deact_out: assert property ((mode == IM_FFDEACT && act && !mat_on)
    |=> third_ctrl_out0 == $past(s_q.cfg[CFG_POL]) &&
        third_ctrl_out1 == $past(s_q.cfg[CFG_POL]))
    else $error("output active during mode 14 input");
  a_reserved_mode: assert property ((mode > IM_MAX_LOW &&
    mode != IM_FFDEACT && !mat_on)
    |=> third_ctrl_out0 == $past(core_out0 ^ s_q.cfg[CFG_POL]))
    else $error("reserved mode disturbed the output");
  a_matrix_drive: assert property ((mat_on && !deact)
    |=> third_ctrl_out0 == $past(s_q.mat[{1'b0, ramp_idx}]) &&
        third_ctrl_out1 == $past(s_q.mat[{1'b1, ramp_idx}]))
    else $error("matrix value not on the outputs");
  a_dup_a: assert property (dup_out_a ==
    ($past(s_d.ocfg[OCFG_DUPA]) ? third_ctrl_out1 : third_ctrl_out0))
    else $error("duplicate A follows the wrong output");
  a_dup_b: assert property (dup_out_b ==
    ($past(s_d.ocfg[OCFG_DUPB]) ? third_ctrl_out0 : third_ctrl_out1))
    else $error("duplicate B follows the wrong output");
  a_chain_zero: assert property (!CHAIN_EN |-> s_q.ctrl[1:0] == 2'h0 &&
    !run_out && !fault_to_prev)
    else $error("absent chain shows run state");
  a_slave_run: assert property ((CHAIN_EN && s_q.ctrl[CTRL_AUTORUN] &&
    prev_run_in) |=> run_out)
    else $error("autorun slave did not follow its master");
endmodule : pspa_top

// [pspa_pkg.sv]
// Shared constants and types of the power stage auxiliary logic
package pspa_pkg;
  // Bus widths
  localparam int AW = 8;
  localparam int DW = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_OCFG = 8'h08;
  localparam logic [7:0] OFS_MAT = 8'h0C;
  localparam logic [7:0] OFS_DLY = 8'h10;
  localparam logic [7:0] OFS_CAP = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Writable bit masks; other bits read as zero
  localparam logic [31:0] MSK_CTRL = 32'h0000001F;
  localparam logic [31:0] MSK_CHAIN = 32'h00000003;
  localparam logic [31:0] MSK_CFG = 32'h000001FF;
  localparam logic [31:0] MSK_OCFG = 32'h0000001F;
  localparam logic [31:0] MSK_MAT = 32'h000000FF;
  localparam logic [31:0] MSK_DLY = 32'h000000FF;
  localparam logic [31:0] MSK_STAT = 32'h0000000F;
  // Reset value of every register
  localparam logic [31:0] REG_RST = 32'h00000000;
  // control_reg fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_AUTORUN = 1;
  localparam int CTRL_PRE_LO = 2;
  localparam int CTRL_CLKSEL = 4;
  // config_reg fields
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_RUN_LO = 4;
  localparam int CFG_MAT_EN = 6;
  localparam int CFG_POL = 7;
  localparam int CFG_ACT_HI = 8;
  // sync_output_config fields
  localparam int OCFG_DUPA = 0;
  localparam int OCFG_DUPB = 1;
  localparam int OCFG_SRC_LO = 2;
  localparam int OCFG_DLYCLK = 4;
  // Status flag positions
  localparam int ST_RELOAD = 0;
  localparam int ST_ENH = 1;
  localparam int ST_INPUT = 2;
  localparam int ST_SYNCERR = 3;
  // Input mode codes
  localparam logic [3:0] IM_NONE = 4'h0;
  localparam logic [3:0] IM_DEACT = 4'h4;
  localparam logic [3:0] IM_HALT = 4'h7;
  localparam logic [3:0] IM_MAX_LOW = 4'h9;
  localparam logic [3:0] IM_FFDEACT = 4'hE;
  // Running modes
  localparam logic [1:0] RM_ONE = 2'h0;
  localparam logic [1:0] RM_TWO = 2'h1;
  localparam logic [1:0] RM_FOUR = 2'h2;
  localparam logic [1:0] RM_CENTER = 2'h3;
  // Sync source codes
  localparam logic [1:0] SS_LEAD0 = 2'h0;
  localparam logic [1:0] SS_TRAIL0 = 2'h1;
  localparam logic [1:0] SS_LEAD1 = 2'h2;
  localparam logic [1:0] SS_TRAIL1 = 2'h3;
  // Prescaler codes and shift clock divider
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] SHIFT_DIV_LAST = 2'h3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Write channel states
  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } pspa_wr_st_t;
  // Last count of the prescaler for divide by 1, 4, 32, 256
  function automatic logic [7:0] pspa_pre_limit(input logic [1:0] sel);
    case (sel)
      2'h0: pspa_pre_limit = 8'h00;
      2'h1: pspa_pre_limit = 8'h03;
      2'h2: pspa_pre_limit = 8'h1F;
      default: pspa_pre_limit = 8'hFF;
    endcase
  endfunction : pspa_pre_limit
endpackage : pspa_pkg

// [pspa_prescale.sv]
// Clock source selector and prescaler producing the controller tick
`timescale 1ns/100ps
module pspa_prescale (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic io_tick,
  input wire logic pll_tick,
  input wire logic src_pll,
  input wire logic [1:0] div_sel,
  output logic tick_q
);
  import pspa_pkg::*;
  // All state of the prescaler
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } pspa_pre_st_t;
  pspa_pre_st_t s_q, s_d;
  logic src;
  // Source mux and divide counter
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    src = src_pll ? pll_tick : io_tick;
    if (src) begin
      if (s_q.cnt >= pspa_pre_limit(div_sel)) begin
        s_d.cnt = 8'h00;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end
  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick_q = s_q.tick;
  a_div_one: assert property (@(posedge ref_clk) disable iff (!nrst)
    (div_sel == PRE_DIV1 && src) |=> tick_q)
    else $error("prescaler by one missed a tick");
  a_src_io: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!src_pll && !io_tick) |=> !tick_q)
    else $error("tick without a selected source tick");
endmodule : pspa_prescale

// [pspa_sync_delay.sv]
// Programmable delay line for the ADC synchronization pulse
`timescale 1ns/100ps
module pspa_sync_delay #(
  parameter int DLW = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pulse,
  input wire logic shift_en,
  input wire logic [DLW-1:0] delay,
  output logic sync_q
);
  import pspa_pkg::*;
  if (DLW < 1 || DLW > 16) begin : g_bad_width
    $error("delay width out of range");
  end
  // All state of the delay line
  typedef struct packed {
    logic [DLW-1:0] cnt;
    logic busy;
    logic out;
  } pspa_dly_st_t;
  pspa_dly_st_t s_q, s_d;
  // Load on a source edge, count shift ticks, fire at the last
  always_comb begin
    s_d = s_q;
    s_d.out = 1'b0;
    if (pulse) begin
      // A new edge restarts the delay
      if (delay == '0) begin
        s_d.out = 1'b1;
        s_d.busy = 1'b0;
      end else begin
        s_d.cnt = delay;
        s_d.busy = 1'b1;
      end
    end else if (s_q.busy && shift_en) begin
      if (s_q.cnt == DLW'(1)) begin
        s_d.out = 1'b1;
        s_d.busy = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - DLW'(1);
      end
    end
  end
  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_q = s_q.out;
  a_zero_delay: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pulse && delay == '0) |=> sync_q)
    else $error("undelayed sync pulse missing");
  a_no_early: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pulse && delay != '0) |=> !sync_q)
    else $error("delayed sync pulse came early");
endmodule : pspa_sync_delay

// [pspa_far_model.sv]
// Far side model: core ramp waveforms, clock ticks, ADC trigger counter
`timescale 1ns/100ps
module pspa_far_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic adc_sync,
  output logic core_out0,
  output logic core_out1,
  output logic [1:0] ramp_idx,
  output logic [11:0] count_in,
  output logic reload_ev,
  output logic io_tick,
  output int n_sync
);
  // Free running ramp counter
  logic [11:0] cnt_q;
  // Counter advances each cycle; converter counts trigger pulses
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 12'h000;
      n_sync <= 0;
    end else begin
      cnt_q <= cnt_q + 12'h001;
      if (adc_sync === 1'h1) n_sync <= n_sync + 1;
    end
  end
  // Slow waveforms leave room to see edge order
  assign count_in = cnt_q;
  assign core_out0 = cnt_q[4];
  assign core_out1 = cnt_q[5];
  assign ramp_idx = cnt_q[7:6];
  assign reload_ev = (cnt_q[7:0] == 8'hFF);
  assign io_tick = cnt_q[0];
endmodule : pspa_far_model

// [tb.sv]
// Self-checking bench of the power stage auxiliary logic
`timescale 1ns/100ps
module tb;
  import pspa_pkg::*;
  logic ref_clk = 1'h0, nrst = 1'h0, retrig_in = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd, cfg = 32'h0, ocfg = 32'h0;
  logic [31:0] matv = 32'h0;
  logic [3:0] wstrb = 4'hF, md [9] = '{0, 4, 14, 9, 10, 11, 12, 13, 15};
  logic awready, wready, bvalid, arready, rvalid, reload_ev, io_tick;
  logic [1:0] bresp, rresp, ramp_idx, rs;
  logic core_out0, core_out1, out0, out1, dup_a, dup_b, adc_sync, psc_t;
  logic [11:0] count_in, ecap;
  logic [5:0] h0 = 6'h0, h1 = 6'h0;
  logic e0, e1, ea, eb, o0, o1, act, mat, act_p = 1'h0;
  logic ro, fp;
  logic chk_en = 1'h0, rnd_en = 1'h0, sy_en = 1'h0;
  int fails = 0, n_tests = 0, seed = 32'h973d, n_sync, n_tick = 0;
  int i, k, k0, dlt, ex [5] = '{512, 128, 16, 2, 0};
  int ey [8] = '{8, 8, 4, 4, 8, 8, 0, 0};

  always #25 ref_clk = ~ref_clk;

  pspa_top dut (.ref_clk(ref_clk), .nrst(nrst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .core_out0(core_out0), .core_out1(core_out1), .ramp_idx(ramp_idx),
    .count_in(count_in), .reload_ev(reload_ev), .enh_end_ev(reload_ev),
    .sync_err_ev(reload_ev), .retrig_in(retrig_in), .io_tick(io_tick),
    .pll_tick(1'h0), .prev_run_in(1'h0), .next_fault_in(1'h0),
    .run_out(ro), .fault_to_prev(fp), .third_ctrl_out0(out0),
    .third_ctrl_out1(out1), .dup_out_a(dup_a), .dup_out_b(dup_b),
    .adc_sync(adc_sync), .clk_psc_tick(psc_t));

  pspa_far_model far (.ref_clk(ref_clk), .nrst(nrst), .adc_sync(adc_sync),
    .core_out0(core_out0), .core_out1(core_out1), .ramp_idx(ramp_idx),
    .count_in(count_in), .reload_ev(reload_ev), .io_tick(io_tick),
    .n_sync(n_sync));

  // Reference model of the pins, evaluated at each sampling edge
  always @(posedge ref_clk) begin
    act = cfg[CFG_ACT_HI] ? retrig_in : !retrig_in;
    mat = cfg[CFG_MAT_EN] && cfg[5:4] == RM_FOUR;
    o0 = mat ? matv[ramp_idx] : core_out0 ^ cfg[CFG_POL];
    o1 = mat ? matv[4 + ramp_idx] : core_out1 ^ cfg[CFG_POL];
    if (act && (cfg[3:0] == IM_DEACT || cfg[3:0] == IM_FFDEACT)) begin
      o0 = !mat && cfg[CFG_POL];
      o1 = o0;
    end
    e0 <= o0;
    e1 <= o1;
    ea <= ocfg[OCFG_DUPA] ? o1 : o0;
    eb <= ocfg[OCFG_DUPB] ? o0 : o1;
    if (act && !act_p) ecap <= count_in;
    act_p <= act;
    if (rnd_en) retrig_in <= 1'($random(seed));
  end

  // Pin comparisons on settled values
  always @(negedge ref_clk) begin
    h0 <= {h0[4:0], out0};
    h1 <= {h1[4:0], out1};
    if (psc_t === 1'h1) n_tick++;
    if (chk_en) cmp_pin({out0, out1, dup_a, dup_b},
      {e0, e1, ea, eb});
    if (chk_en) cmp_pin({2'h0, ro, fp}, 4'h0); // Chain absent
    // Centered mode swaps the edge sense of codes 0 and 1
    if (chk_en && sy_en && adc_sync === 1'h1)
      cmp_pin({2'h0, ocfg[3] ? {out1, h1[5]} : {out0, h0[5]}},
        (ocfg[2] ^ (cfg[5:4] == RM_CENTER)) ? 4'h1 : 4'h2);
  end

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t pins got %h exp %h", $time, got, exp);
    end
  endtask : cmp_pin

  task automatic give_verdict;
    $display("fails %0d checks %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // A bus wait that ran out ends the run
  task automatic tmo;
    if (k >= 40) begin
      fails++;
      $display("CHECK FAILED %0t bus wait ran out", $time);
      give_verdict();
    end
  endtask : tmo

  // Write one word; pin checks pause while the shadow catches up
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    chk_en = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    rs = bresp;
    bready <= 1'h0;
    tmo();
    if (a == OFS_CFG) cfg = d;
    if (a == OFS_OCFG) ocfg = d;
    if (a == OFS_MAT) matv = d;
    @(posedge ref_clk);
    chk_en = 1'h1;
  endtask : axw

  // Read one word
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'h0;
    tmo();
    @(posedge ref_clk);
  endtask : axr

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'h1;
    @(posedge ref_clk);
    for (i = 0; i < 6; i++) begin
      axr(8'(4 * i), rd);
      cmp_reg(rd, REG_RST); // Reset values
    end
    axr(8'h40, rd);
    cmp_reg({rd[29:0], rs}, {30'h0, RESP_SLVERR}); // Unmapped read
    axw(8'h40, 32'hFFFFFFFF);
    cmp_reg(32'(rs), 32'(RESP_SLVERR)); // Unmapped write
    axw(OFS_CTRL, 32'h1F);
    axr(OFS_CTRL, rd);
    cmp_reg(rd, 32'h1C); // Chain bits stay zero
    // Input modes under random input; two-ramp suits them
    rnd_en = 1'h1;
    for (i = 0; i < 9; i++) begin
      axw(OFS_OCFG, 32'(i & 3));
      axw(OFS_CFG, {23'h0, 1'($random(seed)), 1'($random(seed)), 1'h0,
                    RM_TWO, md[i]});
      repeat (100) @(posedge ref_clk);
    end
    // Output matrix in four-ramp mode with polarity set
    for (i = 0; i < 4; i++) begin
      axw(OFS_MAT, 32'($random(seed)) & MSK_MAT);
      axw(OFS_CFG, {23'h0, 3'h7, RM_FOUR, i[0] ? IM_FFDEACT : IM_NONE});
      repeat (300) @(posedge ref_clk);
    end
    // Two captures; the second overwrites the first
    rnd_en = 1'h0;
    axw(OFS_CFG, 32'h100);
    for (i = 0; i < 2; i++) begin
      retrig_in <= 1'h0;
      repeat (7 + 30 * i) @(posedge ref_clk);
      retrig_in <= 1'h1;
      repeat (3) @(posedge ref_clk);
    end
    retrig_in <= 1'h0;
    axr(OFS_CAP, rd);
    cmp_reg(rd, 32'(ecap)); // Last event kept
    axr(OFS_STAT, rd);
    cmp_reg(rd, 32'hF); // All four flags set
    axw(OFS_STAT, 32'h4);
    cmp_reg(32'(rs), 32'(RESP_OKAY)); // Clear accepted
    axr(OFS_STAT, rd);
    cmp_reg(rd & 32'h4, 32'h0); // Flag cleared
    // Every sync source code, one-ramp then centered mode, no delay
    sy_en = 1'h1;
    for (i = 0; i < 8; i++) begin
      if (i == 4) axw(OFS_CFG, {23'h0, 3'h4, RM_CENTER, IM_HALT});
      axw(OFS_OCFG, 32'(i & 3) << OCFG_SRC_LO);
      k0 = n_sync;
      repeat (256) @(posedge ref_clk);
      cmp_reg(32'(n_sync - k0), 32'(ey[i])); // Pulse count
    end
    // Prescaler ratios on the I/O source, then the idle PLL source
    for (i = 0; i < 5; i++) begin
      axw(OFS_CTRL, i < 4 ? 32'(i) << CTRL_PRE_LO : 32'h10);
      k0 = n_tick;
      repeat (1024) @(posedge ref_clk);
      dlt = n_tick - k0 - ex[i];
      cmp_reg(32'(dlt >= -1 && dlt <= 1), 32'h1); // Tick rate
    end
    // Delayed sync on quarter ticks: held without ticks, then released
    sy_en = 1'h0;
    axw(OFS_OCFG, 32'h1 << OCFG_DLYCLK);
    axw(OFS_DLY, 32'h3);
    for (i = 0; i < 2; i++) begin
      axw(OFS_CTRL, i ? 32'h0 : 32'h10);
      repeat (32) @(posedge ref_clk);
      k0 = n_sync;
      repeat (256) @(posedge ref_clk);
      cmp_reg(32'(n_sync - k0), i ? 32'h8 : 32'h0); // Delay
    end
    give_verdict();
  end
endmodule : tb
